// *** chan_ctrl_if.sv ***
// per-channel control and status bundle between top and channel
`timescale 1ns/10ps
interface chan_ctrl_if;
    logic [7:0] modem_control_reg;
    logic [15:0] divisor;
    logic tx_load;
    logic [7:0] tx_data;
    logic tx_busy;
    logic rx_valid;
    logic [7:0] rx_data;
    logic irq_event;
    logic in_reset;
    modport top (output modem_control_reg, output divisor, output tx_load, output tx_data, output in_reset,
                 input tx_busy, input rx_valid, input rx_data, output irq_event);
    modport chan (input modem_control_reg, input divisor, input tx_load, input tx_data, input in_reset,
                  output tx_busy, output rx_valid, output rx_data, input irq_event);
endinterface

// *** duart_chan.sv ***
// one serial channel: transmitter, receiver and pin control
`include "duart_map.svh"
`timescale 1ns/10ps
module duart_chan (
    input wire clk_sys,
    input wire reset_n,
    chan_ctrl_if.chan ctl,
    input wire serial_in,
    output logic serial_out,
    output logic irq_out,
    output logic irq_oe,
    output logic aux_out_two_n,
    output logic request_send_n,
    output logic terminal_ready_n
);
    // ************************************
    // input synchroniser
    // ************************************
    logic rx_meta;
    logic rx_sync;
    always_ff @(posedge clk_sys) begin
        rx_meta <= serial_in;
        rx_sync <= rx_meta;
    end

    // receive held idle during reset, so the line is ignored
    logic rx_line;
    assign rx_line = ctl.in_reset ? `SERIAL_IDLE : rx_sync;

    // ************************************
    // transmitter
    // ************************************
    duart_pkg::tx_state_t tx_state;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    always_ff @(posedge clk_sys) begin
        if (!reset_n || ctl.in_reset) begin
            tx_state <= duart_pkg::TX_IDLE;
            tx_cnt <= 16'h0000;
            tx_bit <= 3'h0;
            tx_shift <= 8'h00;
            serial_out <= `SERIAL_IDLE;
        end else begin
            unique case (tx_state)
                duart_pkg::TX_IDLE: begin
                    serial_out <= `SERIAL_IDLE;
                    if (ctl.tx_load) begin
                        tx_shift <= ctl.tx_data;
                        tx_cnt <= ctl.divisor;
                        serial_out <= 1'b0;
                        tx_state <= duart_pkg::TX_START;
                    end
                end
                duart_pkg::TX_START, duart_pkg::TX_DATA: begin
                    if (tx_cnt > 16'h0001) begin
                        tx_cnt <= tx_cnt - 16'h0001;
                    end else begin
                        tx_cnt <= ctl.divisor;
                        if (tx_state == duart_pkg::TX_DATA && tx_bit == 3'h7) begin
                            serial_out <= `SERIAL_IDLE; // stop bit
                            tx_state <= duart_pkg::TX_STOP;
                        end else begin
                            if (tx_state == duart_pkg::TX_DATA) begin
                                tx_bit <= tx_bit + 3'h1;
                            end
                            serial_out <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_state <= duart_pkg::TX_DATA;
                        end
                    end
                end
                duart_pkg::TX_STOP: begin
                    tx_bit <= 3'h0;
                    if (tx_cnt > 16'h0001) begin
                        tx_cnt <= tx_cnt - 16'h0001;
                    end else begin
                        tx_state <= duart_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end
    assign ctl.tx_busy = (tx_state != duart_pkg::TX_IDLE);

    // ************************************
    // receiver: mid-bit sampling, ignores modem status inputs
    // ************************************
    logic rx_active;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_shift;
    always_ff @(posedge clk_sys) begin
        if (!reset_n || ctl.in_reset) begin
            rx_active <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
            rx_shift <= 8'h00;
            ctl.rx_valid <= 1'b0;
            ctl.rx_data <= 8'h00;
        end else begin
            ctl.rx_valid <= 1'b0;
            if (!rx_active) begin
                if (!rx_line) begin
                    rx_active <= 1'b1;
                    rx_cnt <= {1'b0, ctl.divisor[15:1]}; // half bit to centre
                    rx_bit <= 4'h0;
                end
            end else if (rx_cnt > 16'h0001) begin
                rx_cnt <= rx_cnt - 16'h0001;
            end else begin
                rx_cnt <= ctl.divisor;
                if (rx_bit == 4'h0 && rx_line) begin
                    rx_active <= 1'b0; // false start, glitch rejected
                end else if (rx_bit == 4'h9) begin
                    rx_active <= 1'b0;
                    if (rx_line) begin
                        ctl.rx_valid <= 1'b1; // framing errors dropped
                        ctl.rx_data <= rx_shift;
                    end
                end else begin
                    if (rx_bit != 4'h0) begin
                        rx_shift <= {rx_line, rx_shift[7:1]};
                    end
                    rx_bit <= rx_bit + 4'h1;
                end
            end
        end
    end

    // ************************************
    // pin control from the modem control register and the irq source
    // ************************************
    // irq drive and aux pin share one bit, so they always move together
    always_ff @(posedge clk_sys) begin
        if (!reset_n || ctl.in_reset) begin
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
            aux_out_two_n <= 1'b1;
            request_send_n <= 1'b1;
            terminal_ready_n <= 1'b1;
        end else begin
            irq_out <= ctl.irq_event;
            irq_oe <= ctl.modem_control_reg[`CTRL_IRQ_EN_BIT];
            aux_out_two_n <= ~ctl.modem_control_reg[`CTRL_IRQ_EN_BIT];
            request_send_n <= ~ctl.modem_control_reg[`CTRL_RTS_BIT];
            terminal_ready_n <= ~ctl.modem_control_reg[`CTRL_DTR_BIT];
        end
    end
endmodule

// *** duart_map.svh ***
// register bit positions, reset values and timing constants for the dual serial pin block
`ifndef DUART_MAP_SVH
`define DUART_MAP_SVH
`define CTRL_DTR_BIT 0
`define CTRL_RTS_BIT 1
`define CTRL_OUT1_BIT 2
`define CTRL_IRQ_EN_BIT 3
`define CTRL_LOOP_BIT 4
`define CTRL_RESET_VAL 8'h00
`define RESET_MIN_NS 40
`define CLK_PERIOD_NS 5
`define RESET_MIN_CYCLES ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SERIAL_IDLE 1'b1
`define DIV_RESET_VAL 16'h0001
`endif

// *** duart_pins.sv ***
// two-channel serial pin block: control ports, reset width qualifier and two channels
`include "duart_map.svh"
`timescale 1ns/10ps
module duart_pins #(
    parameter int RESET_CYCLES = `RESET_MIN_CYCLES
) (
    input wire clk_sys,
    input wire reset_n,
    input wire device_reset,
    input wire [1:0] ctrl_write,
    input wire [7:0] ctrl_wdata,
    input wire [1:0] div_write,
    input wire [15:0] div_wdata,
    input wire [1:0] tx_load,
    input wire [7:0] tx_data,
    output logic [1:0] tx_busy,
    output logic [1:0] rx_valid,
    output logic [7:0] chan_a_rx_data,
    output logic [7:0] chan_b_rx_data,
    input wire [1:0] irq_event,
    output logic [7:0] chan_a_modem_control_reg,
    output logic [7:0] chan_b_modem_control_reg,
    input wire chan_a_serial_in,
    output logic chan_a_serial_out,
    input wire chan_b_serial_in,
    output logic chan_b_serial_out,
    output logic chan_a_irq_out,
    output logic chan_a_irq_oe,
    output logic chan_b_irq_out,
    output logic chan_b_irq_oe,
    output logic chan_a_aux_out_two_n,
    output logic chan_b_aux_out_two_n,
    output logic chan_a_request_send_n,
    output logic chan_a_terminal_ready_n,
    output logic chan_b_request_send_n,
    output logic chan_b_terminal_ready_n,
    input wire chan_a_clear_send_n,
    input wire chan_a_set_ready_n,
    input wire chan_a_carrier_n,
    input wire chan_a_ring_n,
    input wire chan_b_clear_send_n,
    input wire chan_b_set_ready_n,
    input wire chan_b_carrier_n,
    input wire chan_b_ring_n,
    output logic [3:0] chan_a_modem_status_n,
    output logic [3:0] chan_b_modem_status_n
);
    // ************************************
    // device reset pin: synchronise and qualify its width
    // ************************************
    logic rst_meta;
    logic rst_sync;
    logic [7:0] rst_cnt;
    logic in_reset;
    always_ff @(posedge clk_sys) begin
        rst_meta <= device_reset;
        rst_sync <= rst_meta;
    end
    // short pulses are filtered; only a held pulse clears the channels
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rst_cnt <= 8'h00;
            in_reset <= 1'b0;
        end else if (rst_sync) begin
            if (rst_cnt < 8'(RESET_CYCLES)) begin
                rst_cnt <= rst_cnt + 8'h01;
            end else begin
                in_reset <= 1'b1;
            end
        end else begin
            rst_cnt <= 8'h00;
            in_reset <= 1'b0;
        end
    end

    // ************************************
    // modem status inputs: general-purpose only, never fed to serial paths
    // ************************************
    logic [3:0] sta_meta;
    logic [3:0] stb_meta;
    always_ff @(posedge clk_sys) begin
        sta_meta <= {chan_a_ring_n, chan_a_carrier_n, chan_a_set_ready_n, chan_a_clear_send_n};
        stb_meta <= {chan_b_ring_n, chan_b_carrier_n, chan_b_set_ready_n, chan_b_clear_send_n};
        chan_a_modem_status_n <= sta_meta;
        chan_b_modem_status_n <= stb_meta;
    end

    // ************************************
    // per-channel control registers
    // ************************************
    chan_ctrl_if ca ();
    chan_ctrl_if cb ();
    logic [15:0] div_a;
    logic [15:0] div_b;
    always_ff @(posedge clk_sys) begin
        if (!reset_n || in_reset) begin
            chan_a_modem_control_reg <= `CTRL_RESET_VAL;
            chan_b_modem_control_reg <= `CTRL_RESET_VAL;
        end else begin
            if (ctrl_write[0]) begin
                chan_a_modem_control_reg <= ctrl_wdata;
            end
            if (ctrl_write[1]) begin
                chan_b_modem_control_reg <= ctrl_wdata;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n || in_reset) begin
            div_a <= `DIV_RESET_VAL;
            div_b <= `DIV_RESET_VAL;
        end else begin
            if (div_write[0]) begin
                div_a <= div_wdata;
            end
            if (div_write[1]) begin
                div_b <= div_wdata;
            end
        end
    end

    // channel bundles: each channel sees its own controls plus the shared tx_data and in_reset
    assign ca.modem_control_reg = chan_a_modem_control_reg;
    assign ca.divisor = div_a;
    assign ca.tx_load = tx_load[0];
    assign ca.tx_data = tx_data;
    assign ca.in_reset = in_reset;
    assign ca.irq_event = irq_event[0];
    assign cb.modem_control_reg = chan_b_modem_control_reg;
    assign cb.divisor = div_b;
    assign cb.tx_load = tx_load[1];
    assign cb.tx_data = tx_data;
    assign cb.in_reset = in_reset;
    assign cb.irq_event = irq_event[1];
    assign tx_busy = {cb.tx_busy, ca.tx_busy};
    assign rx_valid = {cb.rx_valid, ca.rx_valid};
    assign chan_a_rx_data = ca.rx_data;
    assign chan_b_rx_data = cb.rx_data;

    // ************************************
    // two independent channels
    // ************************************
    duart_chan u_chan_a (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ctl(ca.chan),
        .serial_in(chan_a_serial_in),
        .serial_out(chan_a_serial_out),
        .irq_out(chan_a_irq_out),
        .irq_oe(chan_a_irq_oe),
        .aux_out_two_n(chan_a_aux_out_two_n),
        .request_send_n(chan_a_request_send_n),
        .terminal_ready_n(chan_a_terminal_ready_n)
    );
    duart_chan u_chan_b (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .ctl(cb.chan),
        .serial_in(chan_b_serial_in),
        .serial_out(chan_b_serial_out),
        .irq_out(chan_b_irq_out),
        .irq_oe(chan_b_irq_oe),
        .aux_out_two_n(chan_b_aux_out_two_n),
        .request_send_n(chan_b_request_send_n),
        .terminal_ready_n(chan_b_terminal_ready_n)
    );
endmodule

// *** duart_pins_sva.sv ***
// concurrent checks on the pin side of the dual serial block
`timescale 1ns/10ps
module duart_pins_sva #(
    parameter int RESET_CYCLES = 8
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic device_reset,
    input wire logic [1:0] ctrl_write,
    input wire logic [7:0] ctrl_wdata,
    input wire logic [1:0] tx_load,
    input wire logic [1:0] tx_busy,
    input wire logic [1:0] irq_event,
    input wire logic chan_a_serial_out,
    input wire logic chan_b_serial_out,
    input wire logic chan_a_irq_out,
    input wire logic chan_a_irq_oe,
    input wire logic chan_b_irq_oe,
    input wire logic chan_a_aux_out_two_n,
    input wire logic chan_b_aux_out_two_n,
    input wire logic chan_a_request_send_n,
    input wire logic chan_a_terminal_ready_n,
    input wire logic chan_a_clear_send_n,
    input wire logic chan_a_set_ready_n,
    input wire logic chan_a_carrier_n,
    input wire logic chan_a_ring_n,
    input wire logic [3:0] chan_a_modem_status_n
);
    // ****************
    // helper logic
    // ****************
    logic [7:0] dr_cnt;
    // length of the current device reset pulse, saturating so long pulses stay counted
    always_ff @(posedge clk_sys) begin
        if (!device_reset) begin
            dr_cnt <= 8'h00;
        end else if (dr_cnt != 8'hff) begin
            dr_cnt <= dr_cnt + 8'h01;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    AST_A_CTRL: assert property (
        ctrl_write[0] && !device_reset |-> ##2 chan_a_irq_oe == ctrl_wdata[3] && chan_a_aux_out_two_n == !ctrl_wdata[3])
        else $error("channel a irq drive does not follow control bit");
    AST_B_CTRL: assert property (
        ctrl_write[1] && !device_reset |-> ##2 chan_b_irq_oe == ctrl_wdata[3] && chan_b_aux_out_two_n == !ctrl_wdata[3])
        else $error("channel b irq drive does not follow control bit");
    AST_AUX_TIE: assert property (
        chan_a_aux_out_two_n != chan_a_irq_oe && chan_b_aux_out_two_n != chan_b_irq_oe)
        else $error("aux pin not complementary to irq drive");
    AST_RST_REL: assert property (
        $rose(reset_n) |-> !chan_a_irq_oe && !chan_b_irq_oe && chan_a_serial_out && chan_b_serial_out)
        else $error("outputs not at rest after reset");
    AST_GP_OUT: assert property (
        ctrl_write[0] && !device_reset |-> ##2 chan_a_request_send_n == !ctrl_wdata[1]
            && chan_a_terminal_ready_n == !ctrl_wdata[0])
        else $error("request or ready output wrong");
    AST_TX_START: assert property (
        tx_load == 2'h1 && tx_busy == 2'h0 && !device_reset |=> !chan_a_serial_out && tx_busy[0] && chan_b_serial_out)
        else $error("start bit missing or channel b disturbed");
    AST_TX_IDLE: assert property (
        tx_busy == 2'h0 |-> chan_a_serial_out && chan_b_serial_out)
        else $error("transmit line low while idle");
    AST_STATUS: assert property (
        chan_a_modem_status_n == $past({chan_a_ring_n, chan_a_carrier_n, chan_a_set_ready_n, chan_a_clear_send_n}, 2))
        else $error("modem status does not follow pins");
    AST_IRQ: assert property (
        chan_a_irq_oe && !device_reset && $past(reset_n) |-> chan_a_irq_out == $past(irq_event[0]))
        else $error("irq output does not follow source");
    AST_DEV_RST: assert property (
        dr_cnt > RESET_CYCLES + 6 |-> chan_a_serial_out && chan_b_serial_out && !chan_a_irq_oe && !chan_b_irq_oe)
        else $error("long device reset did not clear outputs");
endmodule
bind duart_pins duart_pins_sva #(.RESET_CYCLES(RESET_CYCLES)) duart_pins_sva_inst (
    .clk_sys, .reset_n, .device_reset, .ctrl_write, .ctrl_wdata, .tx_load, .tx_busy, .irq_event,
    .chan_a_serial_out, .chan_b_serial_out, .chan_a_irq_out, .chan_a_irq_oe, .chan_b_irq_oe,
    .chan_a_aux_out_two_n, .chan_b_aux_out_two_n, .chan_a_request_send_n, .chan_a_terminal_ready_n,
    .chan_a_clear_send_n, .chan_a_set_ready_n, .chan_a_carrier_n, .chan_a_ring_n, .chan_a_modem_status_n
);

// *** duart_pins_test.sv ***
// self-checking bench for the dual serial pin block
`timescale 1ns/10ps
module duart_pins_test;
    localparam int D = 4;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic device_reset = 1'b0;
    logic [1:0] ctrl_write = 2'h0;
    logic [7:0] ctrl_wdata = 8'h00;
    logic [1:0] div_write = 2'h0;
    logic [15:0] div_wdata = 16'h0000;
    logic [1:0] tx_load = 2'h0;
    logic [7:0] tx_data = 8'h00;
    logic [1:0] irq_event = 2'h0;
    logic [3:0] mod_a = 4'hf;
    logic [3:0] mod_b = 4'hf;
    logic [1:0] tx_busy, rx_valid, sin, sout, irq_o, irq_oe, aux_n, rts_n, dtr_n;
    logic [7:0] rx_a, rx_b, ctrl_a, ctrl_b, last_a, last_b;
    logic [3:0] st_a, st_b;
    int fail_count = 0;
    int total_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    duart_pins duart_pins_inst (.clk_sys(clk_sys), .reset_n(reset_n), .device_reset(device_reset),
        .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata), .div_write(div_write), .div_wdata(div_wdata),
        .tx_load(tx_load), .tx_data(tx_data), .tx_busy(tx_busy), .rx_valid(rx_valid),
        .chan_a_rx_data(rx_a), .chan_b_rx_data(rx_b), .irq_event(irq_event),
        .chan_a_modem_control_reg(ctrl_a), .chan_b_modem_control_reg(ctrl_b),
        .chan_a_serial_in(sin[0]), .chan_a_serial_out(sout[0]), .chan_b_serial_in(sin[1]),
        .chan_b_serial_out(sout[1]), .chan_a_irq_out(irq_o[0]), .chan_a_irq_oe(irq_oe[0]),
        .chan_b_irq_out(irq_o[1]), .chan_b_irq_oe(irq_oe[1]), .chan_a_aux_out_two_n(aux_n[0]),
        .chan_b_aux_out_two_n(aux_n[1]), .chan_a_request_send_n(rts_n[0]), .chan_a_terminal_ready_n(dtr_n[0]),
        .chan_b_request_send_n(rts_n[1]), .chan_b_terminal_ready_n(dtr_n[1]),
        .chan_a_clear_send_n(mod_a[0]), .chan_a_set_ready_n(mod_a[1]), .chan_a_carrier_n(mod_a[2]),
        .chan_a_ring_n(mod_a[3]), .chan_b_clear_send_n(mod_b[0]), .chan_b_set_ready_n(mod_b[1]),
        .chan_b_carrier_n(mod_b[2]), .chan_b_ring_n(mod_b[3]), .chan_a_modem_status_n(st_a),
        .chan_b_modem_status_n(st_b));
    line_end line_a_inst (.clk_sys(clk_sys), .line(sin[0]));
    line_end line_b_inst (.clk_sys(clk_sys), .line(sin[1]));
    // ****************
    // helpers
    // ****************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // every driver starts and ends 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // aux pin is only observed, never used as a general output
    function automatic logic [3:0] pin_exp(input logic [7:0] m);
        return {~m[3], m[3], ~m[1], ~m[0]};
    endfunction
    function automatic logic [3:0] pin_of(input int c);
        return {aux_n[c], irq_oe[c], rts_n[c], dtr_n[c]};
    endfunction
    task automatic wr_ctrl(input int ch, input logic [7:0] d);
        ctrl_write[ch] = 1'b1;
        ctrl_wdata = d;
        tick(1);
        ctrl_write = 2'h0;
    endtask
    // a second load while busy carries other data; it must be ignored
    task automatic tx_check(input int ch, input logic [7:0] b);
        logic [7:0] got;
        int n;
        tx_load[ch] = 1'b1;
        tx_data = b;
        tick(1);
        tx_data = ~b;
        tick(1);
        tx_load = 2'h0;
        check(sout[ch], 1'b0);
        for (int i = 0; i < 8; i++) begin
            tick(D);
            got[i] = sout[ch];
        end
        tick(D);
        check({sout, got}, {2'b11, b});
        n = 0;
        while (tx_busy[ch] && n < 3 * D) begin
            tick(1);
            n++;
        end
        check({tx_busy, sout}, 4'h3);
    endtask
    // watch every cycle of the frame so a one-cycle pulse cannot be missed
    task automatic rx_check(input int ch, input logic [7:0] b, input logic stop);
        logic seen;
        seen = 1'b0;
        fork
            if (ch == 0) line_a_inst.send(b, stop); else line_b_inst.send(b, stop);
            for (int n = 0; n < 12 * D; n++) begin
                tick(1);
                if (rx_valid[ch]) seen = 1'b1;
            end
        join
        check(seen, stop);
        if (stop) check(ch == 0 ? rx_a : rx_b, b);
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [7:0] m;
        logic [7:0] corner [4];
        corner = '{8'h08, 8'h08, 8'hf7, 8'h00};
        void'($urandom(48069));
        tick(20);
        reset_n = 1'b1;
        check({ctrl_a, ctrl_b}, 16'h0000);
        check({aux_n, irq_oe, sout, rts_n, dtr_n}, 10'h33f);
        div_write = 2'h3;
        div_wdata = 16'(D);
        tick(1);
        div_write = 2'h0;
        last_a = 8'h00;
        last_b = 8'h00;
        for (int i = 0; i < 24; i++) begin
            m = (i < 4) ? corner[i] : 8'($urandom);
            mod_a = 4'($urandom);
            mod_b = 4'($urandom);
            irq_event = 2'($urandom);
            wr_ctrl(i % 2, m);
            tick(1);
            check(pin_of(i % 2), pin_exp(m));
            check(pin_of(1 - i % 2), pin_exp(i % 2 ? last_a : last_b));
            check(irq_o, irq_event);
            tick(1);
            check({st_a, st_b}, {mod_a, mod_b});
            if (i % 2) last_b = m; else last_a = m;
        end
        for (int i = 0; i < 8; i++) begin
            mod_a = 4'($urandom);
            tx_check(i % 2, i < 2 ? 8'h80 : 8'($urandom));
            rx_check(i % 2, i < 2 ? 8'h01 : 8'($urandom), i != 4);
        end
        wr_ctrl(0, 8'h0b);
        tick(1);
        device_reset = 1'b1;
        tick(24);
        device_reset = 1'b0;
        check({pin_of(0), ctrl_a}, 12'hb00);
        tick(8);
        wr_ctrl(0, 8'h08);
        tick(1);
        device_reset = 1'b1;
        tick(4);
        device_reset = 1'b0;
        tick(16);
        check(pin_of(0), pin_exp(8'h08));
        end_sim();
    end
    // the whole sequence takes about 900 cycles
    initial begin
        #60000;
        fail_count++;
        end_sim();
    end
endmodule

// *** duart_pkg.sv ***
// types shared by the dual serial pin block
package duart_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } tx_state_t;
endpackage

// *** line_end.sv ***
// far-end serial transmitter model driving one receive line of the block
`timescale 1ns/10ps
module line_end (
    input wire logic clk_sys,
    output logic line
);
    int bit_cycles = 4;
    // the line rests high between characters
    initial line = 1'b1;
    // one character, lsb first; a zero stop bit only when a test asks for a framing fault
    task automatic send(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            #1 line = frame[i];
            repeat (bit_cycles - 1) @(posedge clk_sys);
        end
        @(posedge clk_sys);
        #1 line = 1'b1;
    endtask
endmodule
